/* inc/jrpa_pkg.sv */
// Constants, TAP states and carrier structs for the register packet port.
// Assumes the test clock and the core clock are unrelated in phase.
package jrpa_pkg;

   // Instruction and register lengths
   localparam int unsigned IR_LEN   = 8;
   localparam int unsigned CTRL_LEN = 12;
   localparam int unsigned PKT_LEN  = 72;

   // Instruction codes
   localparam logic [7:0] INSTR_DATA = 8'h25;  // Packet register
   localparam logic [7:0] INSTR_CTRL = 8'h26;  // Access control register
   localparam logic [7:0] IR_CAPT    = 8'h01;  // Fixed capture pattern
   localparam logic [7:0] IR_RESET   = 8'hFF;  // Bypass after reset

   // Control register fields
   localparam int unsigned CT_MUX_WR = 6;
   localparam int unsigned CT_IN_HI  = 5;
   localparam int unsigned CT_IN_LO  = 4;
   localparam int unsigned CT_B2_HI  = 3;
   localparam int unsigned CT_B2_LO  = 2;
   localparam int unsigned CT_B1_HI  = 1;
   localparam int unsigned CT_B1_LO  = 0;
   localparam logic [1:0]  SEL_RD_REG  = 2'h0;  // Read register value
   localparam logic [1:0]  SEL_RD_STAT = 2'h1;  // Read pin status
   localparam logic [1:0]  SEL_WR      = 2'h2;  // Write register

   // Field widths
   localparam int unsigned CMP_W  = 20;
   localparam int unsigned RES_W  = 12;
   localparam int unsigned SEL_W  = 4;
   localparam int unsigned IN_W   = 3;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned GP2_W  = 6;

   // Packet bit positions
   localparam int unsigned PK_CMP_HI = 71;
   localparam int unsigned PK_RES_D0 = 43;
   localparam int unsigned PK_CONVERTER_SELECT_BIT0   = 31;
   localparam int unsigned PK_CONVERTER_ATTENUATE  = 27;
   localparam int unsigned PK_IN2    = 22;
   localparam int unsigned PK_B2_HI  = 15;
   localparam int unsigned PK_B1_HI  = 7;

   // Reset values of the writable registers
   localparam logic [7:0] GP1_RST = 8'h04;

   // TAP states, one-bit steps from capture through shift to exit-1
   typedef enum logic [3:0] {
      TS_TLR  = 4'h0, TS_RTI  = 4'h1, TS_SDS  = 4'h3, TS_CDR  = 4'h2,
      TS_SHDR = 4'h6, TS_E1DR = 4'h7, TS_PDR  = 4'h5, TS_E2DR = 4'h4,
      TS_UDR  = 4'hC, TS_SIS  = 4'hD, TS_CIR  = 4'hF, TS_SHIR = 4'hE,
      TS_E1IR = 4'hA, TS_PIR  = 4'hB, TS_E2IR = 4'h9, TS_UIR  = 4'h8
   } jrpa_tap_t;

   // Snapshot of everything the packet can read
   typedef struct packed {
      logic [CMP_W-1:0]  cmp;    // A/B pairs, monitor 1 first
      logic [RES_W-1:0]  res;    // Converter result
      logic [IN_W-1:0]   pin;    // Logic inputs 2..4
      logic [BYTE_W-1:0] ost0;   // Output state first
      logic [BYTE_W-1:0] ost1;   // Output state second
      logic [SEL_W-1:0]  sel;    // Converter input select
      logic              converter_attenuate;  // Converter attenuate
      logic [IN_W-1:0]   inval;  // Logic input value
      logic [BYTE_W-1:0] gp1;    // General output first
      logic [GP2_W-1:0]  gp2;    // General output second
   } jrpa_snap_t;

   // Write request from the test clock side
   typedef struct packed {
      logic              en_mux;
      logic              en_in;
      logic              en_gp1;
      logic              en_gp2;
      logic [SEL_W-1:0]  sel;
      logic              converter_attenuate;
      logic [IN_W-1:0]   inval;
      logic [BYTE_W-1:0] gp1;
      logic [GP2_W-1:0]  gp2;
   } jrpa_wr_t;

endpackage : jrpa_pkg

/* rtl/jrpa_port.sv */
// Test-port access to the supervisor register set via a 72-bit packet.
// Assumes core inputs are on core_clk_i except the logic input pins.
`timescale 1ns/1ps

// Function
// - Code 25h selects 72-bit packet path
// - Code 26h selects 12-bit access control
// - Packet reads all, writes writable registers
// - Capture, shift, update per TAP data column
// - Nine bytes: status, result, mux, inputs, outputs
// - Byte 9 most significant, bit 71 last
// - Bits 71..52 comparator pairs, 51..48 ones
// - Comparator bytes ignored on write
// - Result bits placed reversed; 47..44 ones
// - Control bit 6 enables mux byte write
// - Byte 4 reads current mux and attenuate
// - Bits 5:4 = 10 writes input value
// - Bits 5:4 = 00 reads input value
// - Bits 5:4 = 01 reads input pin status
// - Pattern 10 writes general output bytes
// - Pattern 00 reads general output bytes
// - Pattern 01 reads output status bytes
// - Output status: high-voltage then digital drives
// - Bits without function read as one
module jrpa_port
   import jrpa_pkg::*;
(
   input  wire logic              core_clk_i,         // Core clock, 25 MHz
   input  wire logic              arst_n_i,           // Async reset, active low
   input  wire logic              tck_i,              // Test clock
   input  wire logic              tms_i,              // Test mode select
   input  wire logic              tdi_i,              // Test data in
   output logic                   tdo_o,              // Test data out
   output logic                   tdo_oe_o,           // Test data out enable
   input  wire logic [CMP_W-1:0]  mon_cmp_i,          // Comparator pairs
   input  wire logic [RES_W-1:0]  conv_result_i,      // Converter result
   input  wire logic [IN_W-1:0]   logic_input_pin_i,  // Input pins 2..4
   input  wire logic [BYTE_W-1:0] output_state_first_i,  // Drive state
   input  wire logic [BYTE_W-1:0] output_state_second_i, // Drive state
   output logic [SEL_W-1:0]       conv_select_o,      // Converter input select
   output logic                   conv_attenuate_o,   // Converter attenuate
   output logic [IN_W-1:0]        logic_input_value_o, // To sequencing logic
   output logic [BYTE_W-1:0]      general_output_first_o,  // Drive register
   output logic [GP2_W-1:0]       general_output_second_o  // Drive register
);

   // Core-side state
   typedef struct packed {
      jrpa_snap_t        hold;     // Snapshot offered to test side
      logic              req;      // Snapshot toggle
      logic              busy;     // Waiting for acknowledge
      logic              wr_seen;  // Last write toggle taken
      logic [SEL_W-1:0]  sel;
      logic              converter_attenuate;
      logic [IN_W-1:0]   inval;
      logic [BYTE_W-1:0] gp1;
      logic [GP2_W-1:0]  gp2;
   } jrpa_core_t;

   // Test-clock-side state
   typedef struct packed {
      logic [IR_LEN-1:0]   ir;       // Active instruction
      logic [IR_LEN-1:0]   ir_sh;    // Instruction shifter
      logic [CTRL_LEN-1:0] ctrl;     // Access control
      logic [CTRL_LEN-1:0] ctrl_sh;  // Control shifter
      logic [PKT_LEN-1:0]  pkt_sh;   // Packet shifter
      logic                byp;      // Bypass bit
      jrpa_snap_t          mirror;   // Latest core snapshot
      logic                ack;      // Snapshot acknowledge toggle
      jrpa_wr_t            wr;       // Pending write
      logic                wr_tgl;   // Write toggle
   } jrpa_jt_t;

   // Falling-edge output state
   typedef struct packed {
      logic tdo;
      logic oe;
   } jrpa_out_t;

   jrpa_core_t     c_q, c_d;     // Core registers
   jrpa_jt_t       t_q, t_d;     // Test clock registers
   jrpa_out_t      o_q, o_d;     // Output stage
   jrpa_tap_t      st;           // TAP state
   jrpa_snap_t     live;         // Current core values
   logic [IN_W-1:0] pin_s;       // Synchronised input pins
   logic           ack_s;        // Acknowledge in core domain
   logic           wr_s;         // Write toggle in core domain
   logic           req_s;        // Snapshot toggle in test domain
   logic           wr_evt;       // New write arrived
   logic           sel_data;     // Packet instruction active
   logic           sel_ctrl;     // Control instruction active

   // TAP controller
   jrpa_tap u_tap (
      .tck_i    (tck_i),
      .arst_n_i (arst_n_i),
      .tms_i    (tms_i),
      .state_o  (st)
   );

   // Pins from outside pass two flops first
   jrpa_sync #(.WIDTH(IN_W)) u_pin_sync (
      .clk_i    (core_clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (logic_input_pin_i),
      .q_o      (pin_s)
   );

   // Snapshot acknowledge back to core
   jrpa_sync #(.WIDTH(1)) u_ack_sync (
      .clk_i    (core_clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (t_q.ack),
      .q_o      (ack_s)
   );

   // Write toggle into core
   jrpa_sync #(.WIDTH(1)) u_wr_sync (
      .clk_i    (core_clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (t_q.wr_tgl),
      .q_o      (wr_s)
   );

   // Snapshot toggle into test domain
   jrpa_sync #(.WIDTH(1)) u_req_sync (
      .clk_i    (tck_i),
      .arst_n_i (arst_n_i),
      .d_i      (c_q.req),
      .q_o      (req_s)
   );

   // Build the read packet from a snapshot and the control word
   function automatic logic [PKT_LEN-1:0] pkt_build(
      input jrpa_snap_t          s,
      input logic [CTRL_LEN-1:0] c
   );
      logic [PKT_LEN-1:0] p;
      p = '1;
      p[PK_CMP_HI -: CMP_W] = s.cmp;
      for (int i = 0; i < RES_W; i++) begin
         p[PK_RES_D0 - i] = s.res[i];
      end
      // Mux byte always reads back current select and attenuate, whatever control bit 6 says
      for (int i = 0; i < SEL_W; i++) begin
         p[PK_CONVERTER_SELECT_BIT0 - i] = s.sel[i];
      end
      p[PK_CONVERTER_ATTENUATE] = s.converter_attenuate;
      case (c[CT_IN_HI:CT_IN_LO])
         SEL_RD_REG:  p[PK_IN2 -: IN_W] = s.inval;
         SEL_RD_STAT: p[PK_IN2 -: IN_W] = s.pin;
         default:     ;                                     // Ones
      endcase
      case (c[CT_B2_HI:CT_B2_LO])
         SEL_RD_REG:  p[PK_B2_HI -: BYTE_W] = s.gp1;
         SEL_RD_STAT: p[PK_B2_HI -: BYTE_W] = s.ost0;
         default:     ;                                     // Ones
      endcase
      case (c[CT_B1_HI:CT_B1_LO])
         SEL_RD_REG:  p[PK_B1_HI -: GP2_W] = s.gp2;
         SEL_RD_STAT: p[PK_B1_HI -: BYTE_W] = s.ost1;
         default:     ;                                     // Ones
      endcase
      return p;
   endfunction : pkt_build

   // Live values seen by the core side
   always_comb begin
      live       = '0;
      live.cmp   = mon_cmp_i;
      live.res   = conv_result_i;
      live.pin   = pin_s;
      live.ost0  = output_state_first_i;
      live.ost1  = output_state_second_i;
      live.sel   = c_q.sel;
      live.converter_attenuate = c_q.converter_attenuate;
      live.inval = c_q.inval;
      live.gp1   = c_q.gp1;
      live.gp2   = c_q.gp2;
   end

   assign wr_evt = (wr_s != c_q.wr_seen);

   // Core next state: snapshot handshake and register writes
   always_comb begin
      c_d = c_q;
      // New snapshot only after the last one was taken
      if (!c_q.busy) begin
         c_d.hold = live;
         c_d.req  = ~c_q.req;
         c_d.busy = 1'b1;
      end else if (ack_s == c_q.req) begin
         c_d.busy = 1'b0;
      end
      // Write data is stable while its toggle travels
      if (wr_evt) begin
         c_d.wr_seen = wr_s;
         if (t_q.wr.en_mux) begin
            c_d.sel   = t_q.wr.sel;
            c_d.converter_attenuate = t_q.wr.converter_attenuate;
         end
         if (t_q.wr.en_in) begin
            c_d.inval = t_q.wr.inval;
         end
         if (t_q.wr.en_gp1) begin
            c_d.gp1 = t_q.wr.gp1;
         end
         if (t_q.wr.en_gp2) begin
            c_d.gp2 = t_q.wr.gp2;
         end
      end
   end

   // Core registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         c_q     <= '0;
         c_q.gp1 <= GP1_RST;
      end else begin
         c_q <= c_d;
      end
   end

   assign sel_data = (t_q.ir == INSTR_DATA);
   assign sel_ctrl = (t_q.ir == INSTR_CTRL);

   // Test clock next state
   always_comb begin
      t_d = t_q;
      // Take a fresh snapshot whenever the core offers one
      if (req_s != t_q.ack) begin
         t_d.mirror = c_q.hold;
         t_d.ack    = req_s;
      end
      case (st)
         TS_TLR:  t_d.ir = IR_RESET;
         TS_CIR:  t_d.ir_sh = IR_CAPT;
         TS_SHIR: t_d.ir_sh = {tdi_i, t_q.ir_sh[IR_LEN-1:1]};
         TS_UIR:  t_d.ir = t_q.ir_sh;
         TS_CDR: begin
            if (sel_data) begin
               t_d.pkt_sh = pkt_build(t_q.mirror, t_q.ctrl);
            end else if (sel_ctrl) begin
               t_d.ctrl_sh = t_q.ctrl;
            end else begin
               t_d.byp = 1'b0;
            end
         end
         TS_SHDR: begin
            // Least significant bit leaves first
            if (sel_data) begin
               t_d.pkt_sh = {tdi_i, t_q.pkt_sh[PKT_LEN-1:1]};
            end else if (sel_ctrl) begin
               t_d.ctrl_sh = {tdi_i, t_q.ctrl_sh[CTRL_LEN-1:1]};
            end else begin
               t_d.byp = tdi_i;
            end
         end
         TS_UDR: begin
            if (sel_ctrl) begin
               t_d.ctrl = t_q.ctrl_sh;
            end else if (sel_data) begin
               // Comparator and result bytes are never taken
               t_d.wr.en_mux = t_q.ctrl[CT_MUX_WR];
               t_d.wr.en_in  = (t_q.ctrl[CT_IN_HI:CT_IN_LO] == SEL_WR);
               t_d.wr.en_gp1 = (t_q.ctrl[CT_B2_HI:CT_B2_LO] == SEL_WR);
               t_d.wr.en_gp2 = (t_q.ctrl[CT_B1_HI:CT_B1_LO] == SEL_WR);
               for (int i = 0; i < SEL_W; i++) begin
                  t_d.wr.sel[i] = t_q.pkt_sh[PK_CONVERTER_SELECT_BIT0 - i];
               end
               t_d.wr.converter_attenuate = t_q.pkt_sh[PK_CONVERTER_ATTENUATE];
               t_d.wr.inval = t_q.pkt_sh[PK_IN2 -: IN_W];
               t_d.wr.gp1   = t_q.pkt_sh[PK_B2_HI -: BYTE_W];
               t_d.wr.gp2   = t_q.pkt_sh[PK_B1_HI -: GP2_W];
               t_d.wr_tgl   = ~t_q.wr_tgl;
            end
         end
         default: ;
      endcase
   end

   // Test clock registers
   always_ff @(posedge tck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         t_q    <= '0;
         t_q.ir <= IR_RESET;
      end else begin
         t_q <= t_d;
      end
   end

   // Output bit on the falling edge, per TAP timing
   always_comb begin
      o_d = '0;
      if (st == TS_SHIR) begin
         o_d.tdo = t_q.ir_sh[0];
         o_d.oe  = 1'b1;
      end else if (st == TS_SHDR) begin
         o_d.oe = 1'b1;
         if (sel_data) begin
            o_d.tdo = t_q.pkt_sh[0];
         end else if (sel_ctrl) begin
            o_d.tdo = t_q.ctrl_sh[0];
         end else begin
            o_d.tdo = t_q.byp;
         end
      end
   end

   // Output stage register
   always_ff @(negedge tck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         o_q <= '0;
      end else begin
         o_q <= o_d;
      end
   end

   assign tdo_o                   = o_q.tdo;
   assign tdo_oe_o                = o_q.oe;
   assign conv_select_o           = c_q.sel;
   assign conv_attenuate_o        = c_q.converter_attenuate;
   assign logic_input_value_o     = c_q.inval;
   assign general_output_first_o  = c_q.gp1;
   assign general_output_second_o = c_q.gp2;

   // Core-side checks
   a_gp_write_load: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      wr_evt && t_q.wr.en_gp1 |=> general_output_first_o == $past(t_q.wr.gp1))
      else $error("general output not loaded");
   a_gp_hold_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !wr_evt |=> $stable(general_output_first_o) && $stable(general_output_second_o))
      else $error("general output changed without write");
   a_mux_ignored: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      wr_evt && !t_q.wr.en_mux |=> $stable(conv_select_o) && $stable(conv_attenuate_o))
      else $error("mux written while disabled");
   a_inval_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      wr_evt && t_q.wr.en_in |=> logic_input_value_o == $past(t_q.wr.inval))
      else $error("input value not loaded");

   // Test-side checks
   a_ctrl_update: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_UDR && sel_ctrl |=> t_q.ctrl == $past(t_q.ctrl_sh))
      else $error("control not updated");
   a_pkt_ones: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_CDR && sel_data |=> t_q.pkt_sh[51:44] == 8'hFF)
      else $error("fixed ones missing");
   a_pkt_cmp_cap: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_CDR && sel_data |=> t_q.pkt_sh[71:52] == $past(t_q.mirror.cmp))
      else $error("comparator bits wrong");
   a_pkt_shift_lsb: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_SHDR && sel_data |=>
         t_q.pkt_sh == {$past(tdi_i), $past(t_q.pkt_sh[71:1])})
      else $error("packet shift wrong");
   a_wr_only_update: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      st != TS_UDR |=> t_q.wr_tgl == $past(t_q.wr_tgl))
      else $error("write outside update");
   a_tdo_enable: assert property (@(posedge tck_i) disable iff (!arst_n_i)
      tdo_oe_o == (st == TS_SHDR || st == TS_SHIR))
      else $error("test data enable wrong");

   // Main scenarios
   c_pkt_write: cover property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_UDR && sel_data);
   c_ctrl_write: cover property (@(posedge tck_i) disable iff (!arst_n_i)
      st == TS_UDR && sel_ctrl);
   c_gp_loaded: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
      wr_evt && t_q.wr.en_gp1);

endmodule : jrpa_port

/* rtl/jrpa_sync.sv */
// Two-flop synchroniser for levels and toggles.
// Assumes the input is a level or toggle from another clock domain.
`timescale 1ns/1ps
module jrpa_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_i,    // Destination clock
   input  wire logic             arst_n_i, // Async reset, active low
   input  wire logic [WIDTH-1:0] d_i,      // Asynchronous input
   output logic      [WIDTH-1:0] q_o       // Synchronised output
);
   logic [WIDTH-1:0] meta_q;  // First stage, read only by second

   // Plain two-stage chain
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : jrpa_sync

/* rtl/jrpa_tap.sv */
// TAP controller state machine on the test clock.
// Assumes TMS is driven synchronously to the test clock.
`timescale 1ns/1ps
module jrpa_tap
   import jrpa_pkg::*;
(
   input  wire logic tck_i,    // Test clock
   input  wire logic arst_n_i, // Async reset, active low
   input  wire logic tms_i,    // Test mode select
   output jrpa_tap_t state_o   // Present TAP state
);
   jrpa_tap_t st_d;  // Next state

   // Standard sixteen-state walk
   always_comb begin
      case (state_o)
         TS_TLR:  st_d = tms_i ? TS_TLR  : TS_RTI;
         TS_RTI:  st_d = tms_i ? TS_SDS  : TS_RTI;
         TS_SDS:  st_d = tms_i ? TS_SIS  : TS_CDR;
         TS_CDR:  st_d = tms_i ? TS_E1DR : TS_SHDR;
         TS_SHDR: st_d = tms_i ? TS_E1DR : TS_SHDR;
         TS_E1DR: st_d = tms_i ? TS_UDR  : TS_PDR;
         TS_PDR:  st_d = tms_i ? TS_E2DR : TS_PDR;
         TS_E2DR: st_d = tms_i ? TS_UDR  : TS_SHDR;
         TS_UDR:  st_d = tms_i ? TS_SDS  : TS_RTI;
         TS_SIS:  st_d = tms_i ? TS_TLR  : TS_CIR;
         TS_CIR:  st_d = tms_i ? TS_E1IR : TS_SHIR;
         TS_SHIR: st_d = tms_i ? TS_E1IR : TS_SHIR;
         TS_E1IR: st_d = tms_i ? TS_UIR  : TS_PIR;
         TS_PIR:  st_d = tms_i ? TS_E2IR : TS_PIR;
         TS_E2IR: st_d = tms_i ? TS_UIR  : TS_SHIR;
         TS_UIR:  st_d = tms_i ? TS_SDS  : TS_RTI;
         default: st_d = TS_TLR;
      endcase
   end

   // Five TMS highs also return here, so no test reset pin
   always_ff @(posedge tck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_o <= TS_TLR;
      end else begin
         state_o <= st_d;
      end
   end
endmodule : jrpa_tap

/* verif/jrpa_host.sv */
// Test-port host model: walks the TAP and shifts IR and DR scans.
// Assumes the device TAP sits in Test-Logic-Reset or Run-Test-Idle.
`timescale 1ns/1ps
module jrpa_host (
   output logic      tck_o, // Test clock, runs only during ticks
   output logic      tms_o, // Test mode select
   output logic      tdi_o, // Test data in
   input  wire logic tdo_i  // Test data out
);
   // Test clock is held low by the host between ticks
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // One 32 ns test clock: change after fall, sample at rise
   task tick(input logic m, input logic d, output logic o);
      tms_o = m;
      tdi_o = d;
      #16 o = tdo_i;
      tck_o = 1'b1;
      #16 tck_o = 1'b0;
   endtask : tick

   // Capture, shift n bits LSB first, update, back to idle
   task scan(input logic ir, input int n, input logic [71:0] din,
             output logic [71:0] dout);
      logic t;
      dout = '1;
      repeat (4) tick(1'b0, 1'b0, t);   // Idle clocks let the snapshot refresh
      tick(1'b1, 1'b0, t);
      if (ir) tick(1'b1, 1'b0, t);        // Instruction column
      tick(1'b0, 1'b0, t);                // Capture
      tick(1'b0, 1'b0, t);                // Enter shift
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b0, t);                // Update
      tick(1'b0, 1'b0, t);                // Idle, clock then stops
   endtask : scan
endmodule : jrpa_host

/* verif/tb.sv */
// Self-checking bench: packet writes and reads through the test port.
// Assumes the host model owns the test clock; core clock is 25 MHz.
`timescale 1ns/1ps
module tb;
   import jrpa_pkg::*;
   logic core_clk = 1'b0, arst_n = 1'b0, tck, tms, tdi, tdo, t, oe;
   logic [19:0] mon_cmp = 20'hA5C3E;   // Comparator pairs
   logic [11:0] conv_res = 12'h1E7;    // Converter result
   logic [2:0] pin = 3'h4, e_inv = 3'h0;
   logic [7:0] ost0 = 8'h9D, ost1 = 8'h62, e_gp1 = 8'h04;
   logic [3:0] e_sel = 4'h0;            // Expected register model
   logic [5:0] e_gp2 = 6'h00;
   logic e_att = 1'b0;
   logic [3:0] sel_o;
   logic att_o;
   logic [2:0] inv_o;
   logic [7:0] gp1_o;
   logic [5:0] gp2_o;
   logic [71:0] r, w;
   int err_count = 0, checked = 0;

   // Core clock, 40 ns period
   always #20 core_clk = ~core_clk;

   jrpa_host i_jrpa_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
   jrpa_port i_jrpa_port (.core_clk_i(core_clk), .arst_n_i(arst_n), .tck_i(tck),
      .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .mon_cmp_i(mon_cmp),
      .conv_result_i(conv_res), .logic_input_pin_i(pin),
      .output_state_first_i(ost0), .output_state_second_i(ost1),
      .conv_select_o(sel_o), .conv_attenuate_o(att_o), .logic_input_value_o(inv_o),
      .general_output_first_o(gp1_o), .general_output_second_o(gp2_o));

   // Packet expected for a control word; unused bits read as one
   function automatic logic [71:0] exp_pkt(input logic [11:0] c);
      logic [71:0] p;
      p = '1;
      p[71:52] = mon_cmp;
      for (int i = 0; i < 12; i++) p[43-i] = conv_res[i];
      for (int i = 0; i < 4; i++) p[31-i] = e_sel[i];
      p[27] = e_att;
      if (c[5:4] == SEL_RD_REG) p[22:20] = e_inv;
      else if (c[5:4] == SEL_RD_STAT) p[22:20] = pin;
      if (c[3:2] == SEL_RD_REG) p[15:8] = e_gp1;
      else if (c[3:2] == SEL_RD_STAT) p[15:8] = ost0;
      if (c[1:0] == SEL_RD_REG) p[7:2] = e_gp2;
      else if (c[1:0] == SEL_RD_STAT) p[7:0] = ost1;
      return p;
   endfunction : exp_pkt

   task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Instruction scan then data scan of n bits
   task automatic acc(input logic [7:0] ins, input int n, input logic [71:0] d,
                      output logic [71:0] q);
      logic [71:0] x;
      i_jrpa_host.scan(1'b1, IR_LEN, {64'h0, ins}, x);
      i_jrpa_host.scan(1'b0, n, d, q);
      repeat (10) @(posedge core_clk);   // Core write lands in 3-4 clocks
   endtask : acc

   task automatic chk_out();
      chk("outputs", {e_sel, e_att, e_inv, e_gp1, e_gp2},
          {sel_o, att_o, inv_o, gp1_o, gp2_o});
   endtask : chk_out

   task final_report;
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   // Watchdog, over twenty times the expected run
   initial begin
      #500000;
      err_count++;
      final_report;
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      i_jrpa_host.tick(1'b1, 1'b0, t);  // Test clock edge inside reset
      arst_n <= 1'b1;
      @(posedge core_clk);
      chk_out();                                     // Reset values
      chk("tdo enable", 72'h0, {71'h0, oe});
      i_jrpa_host.tick(1'b0, 1'b0, t);
      // Bit 6 set so the mux byte is taken as well
      acc(INSTR_CTRL, CTRL_LEN, 72'h4EA, r);
      chk("ctrl capture", 72'hFFFFFFFFFFFFFFF000, r);
      e_sel = 4'hB;
      e_att = 1'b1;
      e_inv = 3'h6;
      e_gp1 = 8'hC6;
      e_gp2 = 6'h2D;
      w = exp_pkt(12'h000) ^ {20'hFFFFF, 52'h0};  // Comparator bits flipped
      acc(INSTR_DATA, PKT_LEN, w, r);
      chk_out();
      acc(INSTR_CTRL, CTRL_LEN, 72'h000, r);
      chk("ctrl capture", 72'hFFFFFFFFFFFFFFF4EA, r);
      acc(INSTR_DATA, PKT_LEN, ~w, r);
      chk("read regs", exp_pkt(12'h000), r);
      chk("read regs", exp_pkt(12'h000), r);
      chk_out();
      @(posedge core_clk);
      mon_cmp <= 20'h3B1D4;
      conv_res <= 12'hA38;
      pin <= 3'h3;
      ost0 <= 8'h61;
      ost1 <= 8'hD8;
      acc(INSTR_CTRL, CTRL_LEN, 72'h015, r);
      acc(INSTR_DATA, PKT_LEN, ~w, r);
      chk("read status", exp_pkt(12'h015), r);
      chk("tdo enable", 72'h0, {71'h0, oe});
      acc(INSTR_CTRL, CTRL_LEN, 72'h03F, r);
      acc(INSTR_DATA, PKT_LEN, ~w, r);
      chk("read ones", exp_pkt(12'h03F), r);
      chk_out();
      final_report;
   end
endmodule : tb
